// ===== design/iab_exec.sv
`timescale 1ns/10ps
`default_nettype none
module iab_exec (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Instruction issue.
  input  wire logic        issue_valid,
  input  wire logic [31:0] issue_instr,
  input  wire logic [31:0] issue_pc,
  // General register file read data.
  input  wire logic [31:0] general_register_a,
  input  wire logic [31:0] general_register_b,
  // Read addresses toward the register file.
  output logic      [4:0]  rd_addr_a,
  output logic      [4:0]  rd_addr_b,
  // Results.
  output logic             wr_en,
  output logic      [4:0]  wr_addr,
  output logic      [31:0] wr_data,
  output logic             sum_overflow_exception,
  output logic             pc_redirect,
  output logic      [31:0] pc_target,
  output logic             slot_nullified,
  output logic             mem_access_allow
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  iab_dec_if dec_bus ();
  assign dec_bus.instr = issue_instr;
  iab_decode u_decode (
    .d (dec_bus.dec)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Register-file addresses are combinational so operands arrive in the issue cycle.
  assign rd_addr_a = dec_bus.src_a;
  assign rd_addr_b = dec_bus.src_b;
  ////////////////////////////////////////////////////////////////////////////
  logic        wr_en_d, wr_en_q;
  logic [4:0]  wr_addr_d, wr_addr_q;
  logic [31:0] wr_data_d, wr_data_q;
  logic        ovf_d, ovf_q;
  logic        redir_d, redir_q;
  logic [31:0] tgt_d, tgt_q;
  logic        null_d, null_q;
  logic        mem_d, mem_q;
  logic        pend_d, pend_q;
  logic [31:0] pend_tgt_d, pend_tgt_q;
  logic        kill_d, kill_q;
  logic [32:0] wide_sum;
  logic [31:0] imm_sext;
  logic [31:0] br_off;
  logic        equal;
  logic        killed;
  always_comb begin
    wr_en_d    = 1'b0;
    wr_addr_d  = wr_addr_q;
    wr_data_d  = wr_data_q;
    ovf_d      = 1'b0;
    redir_d    = 1'b0;
    tgt_d      = tgt_q;
    null_d     = 1'b0;
    mem_d      = 1'b0;
    pend_d     = pend_q;
    pend_tgt_d = pend_tgt_q;
    kill_d     = kill_q;
    imm_sext   = {{16{dec_bus.imm[15]}}, dec_bus.imm};
    br_off     = {{14{dec_bus.imm[15]}}, dec_bus.imm, 2'b00};
    equal      = (general_register_a == general_register_b);
    wide_sum   = 33'h0_0000_0000;
    killed     = issue_valid && kill_q;
    if (issue_valid) begin
      // A slot instruction resolves any pending redirect and any kill.
      redir_d = pend_q;
      tgt_d   = pend_q ? pend_tgt_q : tgt_q;
      pend_d  = 1'b0;
      kill_d  = 1'b0;
      null_d  = killed;
      mem_d   = !killed;
      if (!killed) begin
        case (dec_bus.op)
          iab_pkg::IAB_OP_TRAP_REG: begin
            wide_sum  = {general_register_a[31], general_register_a} +
                        {general_register_b[31], general_register_b};
            ovf_d     = (wide_sum[32] != wide_sum[31]);
            wr_en_d   = !ovf_d;
            wr_addr_d = dec_bus.dest;
            wr_data_d = wide_sum[31:0];
          end
          iab_pkg::IAB_OP_TRAP_IMM: begin
            wide_sum  = {general_register_a[31], general_register_a} + {imm_sext[31], imm_sext};
            ovf_d     = (wide_sum[32] != wide_sum[31]);
            wr_en_d   = !ovf_d;
            wr_addr_d = dec_bus.src_b;
            wr_data_d = wide_sum[31:0];
          end
          iab_pkg::IAB_OP_MOD_REG: begin
            wr_en_d   = 1'b1;
            wr_addr_d = dec_bus.dest;
            wr_data_d = general_register_a + general_register_b;
          end
          iab_pkg::IAB_OP_MOD_IMM: begin
            wr_en_d   = 1'b1;
            wr_addr_d = dec_bus.src_b;
            wr_data_d = general_register_a + imm_sext;
          end
          iab_pkg::IAB_OP_AND_REG: begin
            wr_en_d   = 1'b1;
            wr_addr_d = dec_bus.dest;
            wr_data_d = general_register_a & general_register_b;
          end
          iab_pkg::IAB_OP_AND_IMM: begin
            wr_en_d   = 1'b1;
            wr_addr_d = dec_bus.src_b;
            wr_data_d = general_register_a & {16'h0000, dec_bus.imm};
          end
          iab_pkg::IAB_OP_BRANCH: begin
            // Target is relative to the delay slot, hence the extra step.
            pend_d     = equal;
            pend_tgt_d = issue_pc + iab_pkg::PC_STEP + br_off;
            kill_d     = dec_bus.likely && !equal;
          end
          default: begin
            mem_d = 1'b1;
          end
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      wr_en_q    <= 1'b0;
      wr_addr_q  <= 5'h00;
      wr_data_q  <= 32'h0000_0000;
      ovf_q      <= 1'b0;
      redir_q    <= 1'b0;
      tgt_q      <= iab_pkg::PC_RESET;
      null_q     <= 1'b0;
      mem_q      <= 1'b0;
      pend_q     <= 1'b0;
      pend_tgt_q <= iab_pkg::PC_RESET;
      kill_q     <= 1'b0;
    end else begin
      wr_en_q    <= wr_en_d;
      wr_addr_q  <= wr_addr_d;
      wr_data_q  <= wr_data_d;
      ovf_q      <= ovf_d;
      redir_q    <= redir_d;
      tgt_q      <= tgt_d;
      null_q     <= null_d;
      mem_q      <= mem_d;
      pend_q     <= pend_d;
      pend_tgt_q <= pend_tgt_d;
      kill_q     <= kill_d;
    end
  end
  assign wr_en                  = wr_en_q;
  assign wr_addr                = wr_addr_q;
  assign wr_data                = wr_data_q;
  assign sum_overflow_exception = ovf_q;
  assign pc_redirect            = redir_q;
  assign pc_target              = tgt_q;
  assign slot_nullified         = null_q;
  assign mem_access_allow       = mem_q;
  ////////////////////////////////////////////////////////////////////////////
  // Checks watch registered outputs one cycle after the issue cycle.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_q);
  sequence s_branch_eq;
    issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_BRANCH && equal;
  endsequence
  // The slot must follow at once; an idle gap leaves these checks to the bench.
  sequence s_next_slot;
    issue_valid;
  endsequence
  chk_ovf_blocks_write: assert property (ovf_q |-> !wr_en_q)
    else $error("write happened with overflow");
  chk_trap_reg_ovf: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_TRAP_REG
      |=> ovf_q == ($past(general_register_a[31]) == $past(general_register_b[31]) &&
          $past(general_register_a[31]) != $past(general_register_a + general_register_b) >> 31))
    else $error("register sum overflow wrong");
  chk_trap_imm_dest: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_TRAP_IMM
      |=> ovf_q || (wr_en_q && wr_addr_q == $past(dec_bus.src_b)))
    else $error("immediate sum destination wrong");
  chk_mod_imm_sum: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_MOD_IMM
      |=> !ovf_q && wr_en_q && wr_data_q == $past(general_register_a + imm_sext))
    else $error("modulo immediate sum wrong");
  chk_mod_reg_sum: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_MOD_REG
      |=> !ovf_q && wr_addr_q == $past(dec_bus.dest) && wr_data_q == $past(general_register_a + general_register_b))
    else $error("modulo register sum wrong");
  chk_reg_and: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_AND_REG
      |=> wr_data_q == $past(general_register_a & general_register_b) && !ovf_q)
    else $error("register and wrong");
  chk_imm_and: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_AND_IMM
      |=> wr_data_q[31:16] == 16'h0000 && wr_addr_q == $past(dec_bus.src_b))
    else $error("immediate and wrong");
  chk_branch_target: assert property (s_branch_eq ##1 issue_valid
      |=> pc_redirect && pc_target == $past(issue_pc, 2) + iab_pkg::PC_STEP +
          ({{16{$past(issue_instr[15], 2)}}, $past(issue_instr[15:0], 2)} << 2))
    else $error("branch redirect or target wrong");
  chk_not_equal_stay: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_BRANCH && !equal
      ##1 s_next_slot |=> !pc_redirect)
    else $error("redirect on unequal branch");
  chk_likely_null: assert property (issue_valid && !killed && dec_bus.op == iab_pkg::IAB_OP_BRANCH
      && dec_bus.likely && !equal ##1 s_next_slot |=> slot_nullified && !wr_en_q && !ovf_q && !mem_access_allow)
    else $error("likely slot not nullified");
endmodule // iab_exec
`default_nettype wire

// ===== design/iab_pkg.sv
package iab_pkg;
  localparam int unsigned XLEN            = 32;
  localparam int unsigned IMM_W           = 16;
  localparam int unsigned BR_SHIFT        = 2;
  localparam int unsigned FLD_OP_HI       = 31;
  localparam int unsigned FLD_OP_LO       = 26;
  localparam int unsigned FLD_SRC_A_HI    = 25;
  localparam int unsigned FLD_SRC_A_LO    = 21;
  localparam int unsigned FLD_SRC_B_HI    = 20;
  localparam int unsigned FLD_SRC_B_LO    = 16;
  localparam int unsigned FLD_DEST_HI     = 15;
  localparam int unsigned FLD_DEST_LO     = 11;
  localparam int unsigned FLD_FUNCT_HI    = 5;
  localparam int unsigned FLD_FUNCT_LO    = 0;
  localparam logic [5:0]  OP_REG_FORM     = 6'h00;
  localparam logic [5:0]  OP_TRAP_IMM     = 6'h08;
  localparam logic [5:0]  OP_MOD_IMM      = 6'h09;
  localparam logic [5:0]  OP_IMM_AND      = 6'h0C;
  localparam logic [5:0]  OP_BR_EQ        = 6'h04;
  localparam logic [5:0]  OP_BR_EQ_LIKELY = 6'h14;
  localparam logic [5:0]  FN_TRAP_SUM     = 6'h20;
  localparam logic [5:0]  FN_MOD_SUM      = 6'h21;
  localparam logic [5:0]  FN_REG_AND      = 6'h24;
  localparam logic [31:0] PC_STEP         = 32'h0000_0004;
  localparam logic [31:0] PC_RESET        = 32'h0000_0000;
  typedef enum logic [2:0] {
    IAB_OP_NONE, IAB_OP_TRAP_REG, IAB_OP_MOD_REG, IAB_OP_AND_REG,
    IAB_OP_TRAP_IMM, IAB_OP_MOD_IMM, IAB_OP_AND_IMM, IAB_OP_BRANCH
  } iab_op_t;
endpackage

// ===== design/iab_dec_if.sv
`timescale 1ns/10ps
`default_nettype none
interface iab_dec_if;
  logic [31:0]       instr;
  iab_pkg::iab_op_t  op;
  logic              likely;
  logic [4:0]        src_a;
  logic [4:0]        src_b;
  logic [4:0]        dest;
  logic [15:0]       imm;
  modport dec (input instr, output op, output likely, output src_a, output src_b, output dest, output imm);
  modport exe (output instr, input op, input likely, input src_a, input src_b, input dest, input imm);
endinterface
`default_nettype wire

// ===== design/iab_decode.sv
`timescale 1ns/10ps
`default_nettype none
module iab_decode (
  // Decoder side.
  iab_dec_if.dec d
);
  logic [5:0] opc;
  logic [5:0] fn;
  always_comb begin
    opc      = d.instr[iab_pkg::FLD_OP_HI:iab_pkg::FLD_OP_LO];
    fn       = d.instr[iab_pkg::FLD_FUNCT_HI:iab_pkg::FLD_FUNCT_LO];
    d.src_a  = d.instr[iab_pkg::FLD_SRC_A_HI:iab_pkg::FLD_SRC_A_LO];
    d.src_b  = d.instr[iab_pkg::FLD_SRC_B_HI:iab_pkg::FLD_SRC_B_LO];
    d.dest   = d.instr[iab_pkg::FLD_DEST_HI:iab_pkg::FLD_DEST_LO];
    d.imm    = d.instr[15:0];
    d.likely = 1'b0;
    d.op     = iab_pkg::IAB_OP_NONE;
    // Unknown opcodes and unknown register-form function codes decode to none.
    if (opc == iab_pkg::OP_REG_FORM) begin
      if (fn == iab_pkg::FN_TRAP_SUM) begin
        d.op = iab_pkg::IAB_OP_TRAP_REG;
      end else if (fn == iab_pkg::FN_MOD_SUM) begin
        d.op = iab_pkg::IAB_OP_MOD_REG;
      end else if (fn == iab_pkg::FN_REG_AND) begin
        d.op = iab_pkg::IAB_OP_AND_REG;
      end
    end else if (opc == iab_pkg::OP_TRAP_IMM) begin
      d.op = iab_pkg::IAB_OP_TRAP_IMM;
    end else if (opc == iab_pkg::OP_MOD_IMM) begin
      d.op = iab_pkg::IAB_OP_MOD_IMM;
    end else if (opc == iab_pkg::OP_IMM_AND) begin
      d.op = iab_pkg::IAB_OP_AND_IMM;
    end else if (opc == iab_pkg::OP_BR_EQ) begin
      d.op = iab_pkg::IAB_OP_BRANCH;
    end else if (opc == iab_pkg::OP_BR_EQ_LIKELY) begin
      d.op     = iab_pkg::IAB_OP_BRANCH;
      d.likely = 1'b1;
    end
  end
endmodule // iab_decode
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        issue_valid = 1'b0;
  logic [31:0] issue_instr = 32'h0;
  logic [31:0] issue_pc = 32'h0;
  logic [31:0] reg_a = 32'h0;
  logic [31:0] reg_b = 32'h0;
  logic [4:0]  rd_addr_a, rd_addr_b, wr_addr;
  logic [31:0] wr_data, pc_target;
  logic        wr_en, ovf, redir, nulled, mem_ok;
  int          n_mismatch = 0;
  int          checked = 0;
  int          seed = 66330;
  int          cycles = 0;
  // Expected results of the issue made one step earlier, and the pending branch.
  logic        e_we, e_ovf, e_red, e_nul, e_mem;
  logic [4:0]  e_wa;
  logic [31:0] e_wd, e_tgt, br_tgt;
  logic        br_pend = 1'b0;
  logic        br_lik, br_tk;
  logic [5:0]  ops [9] = '{6'h00, 6'h00, 6'h00, 6'h08, 6'h09, 6'h0C, 6'h3F, 6'h04, 6'h14};
  logic [5:0]  fns [3] = '{6'h20, 6'h21, 6'h24};
  logic [31:0] edges [4] = '{32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF, 32'h00000001};

  iab_exec i_dut (
    .core_clk(core_clk), .resetn(resetn), .issue_valid(issue_valid), .issue_instr(issue_instr),
    .issue_pc(issue_pc), .general_register_a(reg_a), .general_register_b(reg_b),
    .rd_addr_a(rd_addr_a), .rd_addr_b(rd_addr_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .sum_overflow_exception(ovf), .pc_redirect(redir), .pc_target(pc_target),
    .slot_nullified(nulled), .mem_access_allow(mem_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;

  // A hang is cut short well after the expected run of about 970 cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("Mismatches: %0d, comparisons: %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_prev();
    cmp_flag(wr_en, e_we, "wr_en");
    if (e_we) cmp_val({27'h0, wr_addr}, {27'h0, e_wa}, "wr_addr");
    if (e_we) cmp_val(wr_data, e_wd, "wr_data");
    cmp_flag(ovf, e_ovf, "overflow");
    cmp_flag(redir, e_red, "redirect");
    if (e_red) cmp_val(pc_target, e_tgt, "target");
    cmp_flag(nulled, e_nul, "nullified");
    cmp_flag(mem_ok, e_mem, "mem access");
  endtask

  // Drives one issue and checks the answer to the previous one, so issues run back to back.
  task automatic step(input logic v, input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] a,
                      input logic [31:0] b);
    logic [32:0] s;
    logic [31:0] simm;
    logic [5:0]  op;
    logic        nul;
    @(posedge core_clk);
    issue_valid <= v;
    issue_instr <= ins;
    issue_pc    <= pc;
    reg_a       <= a;
    reg_b       <= b;
    #1;
    check_prev();
    cmp_val({27'h0, rd_addr_a}, {27'h0, ins[25:21]}, "rd_addr_a");
    cmp_val({27'h0, rd_addr_b}, {27'h0, ins[20:16]}, "rd_addr_b");
    op   = ins[31:26];
    simm = {{16{ins[15]}}, ins[15:0]};
    {e_we, e_ovf, e_red, e_nul, e_mem} = {4'h0, v};
    e_wa = ins[15:11];
    if (v) begin
      nul   = br_pend && br_lik && !br_tk;
      e_red = br_pend && br_tk;
      e_tgt = br_tgt;
      br_pend = 1'b0;
      case (op)
        iab_pkg::OP_REG_FORM: begin
          s = {a[31], a} + {b[31], b};
          e_ovf = (ins[5:0] == iab_pkg::FN_TRAP_SUM) && (s[32] != s[31]);
          e_we  = (ins[5:0] == iab_pkg::FN_MOD_SUM) || (ins[5:0] == iab_pkg::FN_REG_AND) || !e_ovf;
          e_wd  = (ins[5:0] == iab_pkg::FN_REG_AND) ? (a & b) : s[31:0];
        end
        iab_pkg::OP_TRAP_IMM, iab_pkg::OP_MOD_IMM: begin
          s = {a[31], a} + {simm[31], simm};
          e_ovf = (op == iab_pkg::OP_TRAP_IMM) && (s[32] != s[31]);
          {e_we, e_wd, e_wa} = {!e_ovf, s[31:0], ins[20:16]};
        end
        iab_pkg::OP_IMM_AND: {e_we, e_wd, e_wa} = {1'b1, a & {16'h0, ins[15:0]}, ins[20:16]};
        iab_pkg::OP_BR_EQ, iab_pkg::OP_BR_EQ_LIKELY: begin
          {br_pend, br_lik, br_tk} = {1'b1, op == iab_pkg::OP_BR_EQ_LIKELY, a == b};
          br_tgt = pc + iab_pkg::PC_STEP + {simm[29:0], 2'b00};
        end
        default: ;
      endcase
      if (nul) {e_we, e_ovf, e_nul, e_mem} = 4'b0010;
    end
  endtask

  // Reset also clears any pending branch, and all registered outputs read as zero meanwhile.
  task automatic do_reset();
    @(posedge core_clk);
    resetn      <= 1'b0;
    issue_valid <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    {e_we, e_ovf, e_red, e_nul, e_mem, br_pend} = 6'h00;
    check_prev();
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Operands lean on the sign boundaries so that both overflow directions occur often.
  task automatic run_ops(input int n, inout logic [31:0] pc);
    int          k;
    logic [31:0] ins, a, b;
    for (int i = 0; i < n; i++) begin
      k   = {$random(seed)} % (br_pend ? 7 : 9);
      // The major opcode overwrites the top of a random word so that it is not cut away.
      ins = $random(seed);
      ins[31:26] = ops[k];
      if (k < 3) ins[10:0] = {5'h00, fns[k]};
      a = ($random(seed) % 3 == 0) ? edges[{$random(seed)} % 4] : $random(seed);
      b = ($random(seed) % 3 == 0) ? edges[{$random(seed)} % 4] : $random(seed);
      if (k > 6 && $random(seed) % 2 == 0) b = a;
      if ({$random(seed)} % 6 == 0) step(1'b0, ins, pc, a, b);
      step(1'b1, ins, pc, a, b);
      pc = pc + 32'h00000004;
    end
    step(1'b0, 32'h0, pc, 32'h0, 32'h0);
  endtask

  initial begin
    logic [31:0] pc;
    pc = 32'h00001000;
    do_reset();
    run_ops(400, pc);
    do_reset();
    run_ops(400, pc);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
